// ---- core/sysref_sync_capture.sv ----
// reference sync pulse capture with APB register access.
// pclk is the digital sample clock; the pulse and the reference clock
// arrive as asynchronous pins and are synchronised before use.
`timescale 1ns/100ps
`include "sysref_consts.svh"

module sysref_sync_capture
	import sysref_pkg::*;
#(
	parameter int DIV_PERIOD = `DIV_PERIOD_DEF,
	parameter int DW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sysref_in,
	input wire logic ref_clk_in,
	output logic sysref_rx_en,
	output logic [DW-1:0] link_div_phase,
	output logic link_div_reset,
	output logic nco_load,
	output logic [23:0] nco_phase,
	output logic sync_aligned
);
	localparam logic [DW-1:0] DIV_LAST = DW'(DIV_PERIOD - 1);
	localparam logic [DW-1:0] DIV_ONE = DW'(1);

	typedef struct packed {
		reg8_t ctrl;
		reg8_t rx_cfg;
		logic rx_en;
		reg8_t win;
		reg8_t clk_cfg;
		reg8_t ph0;
		reg8_t ph1;
		reg8_t ph2;
		logic ref_prev;
		logic ref_cap;
		logic sel_prev;
		align_state_e st;
		logic [1:0] edges;
		logic miss;
		logic [DW-1:0] div;
		logic div_rst;
		logic nco_ld;
		logic [23:0] nco_ph;
		logic aligned;
		logic rdy;
		logic err;
		logic [31:0] rdata;
	} top_s;

	localparam top_s S_RST = '{
		ctrl: `RST_SYNC_CTRL,
		rx_cfg: `RST_RX_CFG,
		rx_en: 1'b1,
		win: `RST_SYNC_WIN,
		clk_cfg: `RST_CLK_CFG,
		ph0: `RST_NCO_PHASE,
		ph1: `RST_NCO_PHASE,
		ph2: `RST_NCO_PHASE,
		ref_prev: 1'b0,
		ref_cap: 1'b0,
		sel_prev: 1'b0,
		st: ST_IDLE,
		edges: 2'h0,
		miss: 1'b0,
		div: '0,
		div_rst: 1'b0,
		nco_ld: 1'b0,
		nco_ph: 24'h000000,
		aligned: 1'b0,
		rdy: 1'b0,
		err: 1'b0,
		rdata: 32'h00000000
	};

	top_s s_q;
	top_s s_d;

	logic [1:0] pins_s;
	logic sysref_s;
	logic ref_clk_s;
	logic retime;
	logic sel;
	logic edge_now;
	logic align;
	logic setup;
	logic commit;
	logic [9:0] idx;
	sync_mode_e mode;
	sync_mode_e new_mode;

	sync_evt_if ev ();

	// the pulse must be wider than a pclk period to be seen reliably
	bit_sync2 #(
		.W(2)
	) u_pins (
		.clk(pclk),
		.rst_n(presetn),
		.d({ref_clk_in, sysref_in}),
		.q(pins_s)
	);

	assign sysref_s = pins_s[0];
	assign ref_clk_s = pins_s[1];

	pulse_qualifier #(
		.PERIOD(DIV_PERIOD),
		.CW(DW)
	) u_qual (
		.clk(pclk),
		.rst_n(presetn),
		.ev(ev)
	);

	function automatic align_state_e start_state(input sync_mode_e m);
		case (m)
			MODE_CONT: start_state = ST_TRACK;
			MODE_ONE_FIRST: start_state = ST_WAIT_FIRST;
			MODE_ONE_SECOND: start_state = ST_WAIT_FIRST;
			default: start_state = ST_IDLE;
		endcase
	endfunction : start_state

	function automatic logic is_mapped(input logic [9:0] i);
		is_mapped = (i == `IDX_NCO_PHASE0) || (i == `IDX_NCO_PHASE1) ||
			(i == `IDX_NCO_PHASE2) || (i == `IDX_RX_CFG) ||
			(i == `IDX_SYNC_CTRL) || (i == `IDX_SYNC_WIN) ||
			(i == `IDX_SYNC_STAT) || (i == `IDX_CLK_CFG);
	endfunction : is_mapped

	function automatic reg8_t read_reg(input logic [9:0] i, input top_s s,
		input logic rt);
		reg8_t stat;
		stat = 8'h00;
		stat[`STAT_ALIGNED_BIT] = s.aligned;
		stat[`STAT_DONE_BIT] = (s.st == ST_LOCKED);
		stat[`STAT_EDGES_LSB +: 2] = s.edges;
		stat[`STAT_MISS_BIT] = s.miss;
		stat[`STAT_RETIME_BIT] = rt;
		if (i == `IDX_NCO_PHASE0) begin
			read_reg = s.ph0;
		end else if (i == `IDX_NCO_PHASE1) begin
			read_reg = s.ph1;
		end else if (i == `IDX_NCO_PHASE2) begin
			read_reg = s.ph2;
		end else if (i == `IDX_RX_CFG) begin
			read_reg = s.rx_cfg;
		end else if (i == `IDX_SYNC_CTRL) begin
			read_reg = s.ctrl;
		end else if (i == `IDX_SYNC_WIN) begin
			read_reg = s.win;
		end else if (i == `IDX_SYNC_STAT) begin
			read_reg = stat;
		end else if (i == `IDX_CLK_CFG) begin
			read_reg = s.clk_cfg;
		end else begin
			read_reg = 8'h00;
		end
	endfunction : read_reg

	assign mode = mode_of(s_q.ctrl);
	assign new_mode = mode_of(pwdata[7:0]);
	assign setup = psel && !penable;
	assign commit = psel && penable && s_q.rdy;
	assign idx = paddr[11:2];

	// ref clock retiming only pays off when bit 3 has been cleared
	assign retime = s_q.clk_cfg[`CLK_SYNTH_BIT] &&
		!s_q.clk_cfg[`CLK_DIRECT_BIT];
	assign sel = retime ? s_q.ref_cap : sysref_s;
	assign edge_now = sel && !s_q.sel_prev &&
		!s_q.rx_cfg[`RX_OFF_BIT];

	assign ev.edge_seen = edge_now;
	assign ev.win_early = s_q.win[`WIN_EARLY_BIT];
	assign ev.win_late = s_q.win[`WIN_LATE_BIT];
	assign ev.track = (s_q.st == ST_TRACK);

	always_comb begin
		s_d = s_q;
		s_d.div_rst = 1'b0;
		s_d.nco_ld = 1'b0;
		align = 1'b0;

		if (setup) begin
			s_d.rdy = 1'b1;
			s_d.err = !is_mapped(idx);
			s_d.rdata = {24'h000000, read_reg(idx, s_q, retime)};
		end else if (commit) begin
			s_d.rdy = 1'b0;
			// the error flag belongs to the access cycle only
			s_d.err = 1'b0;
		end

		// first stage on a ref clock rising edge, then held for pclk
		s_d.ref_prev = ref_clk_s;
		if (ref_clk_s && !s_q.ref_prev) begin
			s_d.ref_cap = sysref_s;
		end
		s_d.sel_prev = sel;

		s_d.div = (s_q.div == DIV_LAST) ? '0 : s_q.div + DIV_ONE;

		// clear first so that a miss in the same cycle survives
		if (commit && pwrite && idx == `IDX_SYNC_STAT &&
			pwdata[`STAT_MISS_BIT]) begin
			s_d.miss = 1'b0;
		end

		case (s_q.st)
			ST_WAIT_FIRST: begin
				if (edge_now) begin
					s_d.edges = 2'h1;
					if (mode == MODE_ONE_FIRST) begin
						align = 1'b1;
						s_d.st = ST_LOCKED;
					end else begin
						s_d.st = ST_WAIT_SECOND;
					end
				end
			end
			ST_WAIT_SECOND: begin
				if (edge_now) begin
					s_d.edges = 2'h2;
					align = 1'b1;
					s_d.st = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				// later pulses leave the link and NCO untouched
				s_d.st = ST_LOCKED;
			end
			ST_TRACK: begin
				if (edge_now && s_q.edges != 2'h3) begin
					s_d.edges = s_q.edges + 2'h1;
				end
				if (ev.realign) begin
					align = 1'b1;
				end
				if (ev.miss) begin
					s_d.miss = 1'b1;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// fixed pipeline depth keeps the offset repeatable; the pin
		// sampling itself still carries the one converter clock spread
		if (align) begin
			s_d.div = '0;
			s_d.div_rst = 1'b1;
			s_d.aligned = 1'b1;
			if (s_q.ctrl[`CTRL_NCO_BIT]) begin
				s_d.nco_ld = 1'b1;
				s_d.nco_ph = {s_q.ph2, s_q.ph1, s_q.ph0};
			end
		end

		if (commit && pwrite) begin
			if (idx == `IDX_NCO_PHASE0) begin
				s_d.ph0 = pwdata[7:0];
			end else if (idx == `IDX_NCO_PHASE1) begin
				s_d.ph1 = pwdata[7:0];
			end else if (idx == `IDX_NCO_PHASE2) begin
				s_d.ph2 = pwdata[7:0];
			end else if (idx == `IDX_RX_CFG) begin
				s_d.rx_cfg = pwdata[7:0];
				s_d.rx_en = !pwdata[`RX_OFF_BIT];
			end else if (idx == `IDX_SYNC_CTRL) begin
				// rewriting the control is the intentional rearm
				s_d.ctrl = pwdata[7:0];
				s_d.st = start_state(new_mode);
				s_d.edges = 2'h0;
				s_d.aligned = 1'b0;
			end else if (idx == `IDX_SYNC_WIN) begin
				s_d.win = pwdata[7:0];
			end else if (idx == `IDX_CLK_CFG) begin
				s_d.clk_cfg = pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= S_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.rdy;
	assign pslverr = s_q.err;
	assign sysref_rx_en = s_q.rx_en;
	assign link_div_phase = s_q.div;
	assign link_div_reset = s_q.div_rst;
	assign nco_load = s_q.nco_ld;
	assign nco_phase = s_q.nco_ph;
	assign sync_aligned = s_q.aligned;
endmodule : sysref_sync_capture

// ---- core/sysref_consts.svh ----
// constants for the reference sync pulse capture: register indexes,
// field positions, reset values and counts; included by the package.
// What this block does
// - in the one-shot modes, alignment stays fixed after a pulse until reset or rearm.
// - with synthesizer on and bit 3 of 0x2BB clear, pulse is caught on ref clock, then resampled.
// - control 0x06 aligns once on the second pulse; later pulses ignored.
// - with control bit 5 set, a qualifying pulse loads all three NCO phase bytes from 0x143 to 0x145.
// - control 0x26 makes the same second pulse also reset NCO phases.
// - early and late window bits at 0x1EA tolerate pulse jitter.
// - initial alignment may differ by one converter clock either way.
// - the pulse aligns the link dividers and the downconverter phase.
`ifndef SYSREF_CONSTS_SVH
`define SYSREF_CONSTS_SVH

`define IDX_NCO_PHASE0 10'h143
`define IDX_NCO_PHASE1 10'h144
`define IDX_NCO_PHASE2 10'h145
`define IDX_RX_CFG 10'h1e7
`define IDX_SYNC_CTRL 10'h1e8
`define IDX_SYNC_WIN 10'h1ea
`define IDX_SYNC_STAT 10'h1eb
`define IDX_CLK_CFG 10'h2bb

`define RST_SYNC_CTRL 8'h00
`define RST_RX_CFG 8'h00
`define RST_SYNC_WIN 8'h00
`define RST_CLK_CFG 8'h08
`define RST_NCO_PHASE 8'h00

`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 2
`define CTRL_NCO_BIT 5
`define RX_OFF_BIT 2
`define WIN_EARLY_BIT 0
`define WIN_LATE_BIT 1
`define CLK_SYNTH_BIT 0
`define CLK_DIRECT_BIT 3

`define STAT_ALIGNED_BIT 0
`define STAT_DONE_BIT 1
`define STAT_EDGES_LSB 2
`define STAT_MISS_BIT 4
`define STAT_RETIME_BIT 5

`define DIV_PERIOD_DEF 32
`define SYSREF_MIN_PULSE_CONV_CLKS 2

`endif

// ---- core/sysref_pkg.sv ----
// types shared by the sync capture modules.
// assumes sysref_consts.svh is on the include path.
`include "sysref_consts.svh"

package sysref_pkg;

	typedef logic [7:0] reg8_t;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_CONT,
		MODE_ONE_FIRST,
		MODE_ONE_SECOND
	} sync_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_FIRST,
		ST_WAIT_SECOND,
		ST_LOCKED,
		ST_TRACK
	} align_state_e;

	function automatic sync_mode_e mode_of(input reg8_t ctrl);
		case (ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB])
			2'h1: mode_of = MODE_CONT;
			2'h2: mode_of = MODE_ONE_FIRST;
			2'h3: mode_of = MODE_ONE_SECOND;
			default: mode_of = MODE_OFF;
		endcase
	endfunction : mode_of

endpackage : sysref_pkg

// ---- core/sync_evt_if.sv ----
// edge events from the capture path to the continuous-mode qualifier.
// both ends run on the same digital sample clock.
`timescale 1ns/100ps

interface sync_evt_if;
	logic edge_seen;
	logic win_early;
	logic win_late;
	logic track;
	logic realign;
	logic miss;

	modport capture (
		output edge_seen,
		output win_early,
		output win_late,
		output track,
		input realign,
		input miss
	);

	modport qualifier (
		input edge_seen,
		input win_early,
		input win_late,
		input track,
		output realign,
		output miss
	);
endinterface : sync_evt_if

// ---- core/bit_sync2.sv ----
// two flip-flop synchroniser for W independent level signals.
// inputs are asynchronous to clk; only the second stage is read.
`timescale 1ns/100ps

module bit_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	always_comb begin
		s_d.meta = d;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.sync;
endmodule : bit_sync2

// ---- core/pulse_qualifier.sv ----
// continuous-mode qualifier: tracks the expected pulse phase and asks for
// realignment only when an edge falls outside the allowed window.
// assumes edges arrive as one-cycle pulses on the same clock.
`timescale 1ns/100ps
`include "sysref_consts.svh"

module pulse_qualifier #(
	parameter int PERIOD = `DIV_PERIOD_DEF,
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	sync_evt_if.qualifier ev
);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
	localparam logic [CW-1:0] ONE = CW'(1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic locked;
		logic realign;
		logic miss;
	} qual_s;

	qual_s s_q;
	qual_s s_d;
	logic in_win;

	always_comb begin
		s_d = s_q;
		s_d.realign = 1'b0;
		s_d.miss = 1'b0;
		s_d.cnt = (s_q.cnt == LAST) ? '0 : s_q.cnt + ONE;
		// cnt is zero exactly one period after the last realigning edge
		in_win = s_q.locked && ((s_q.cnt == '0) ||
			(ev.win_early && s_q.cnt == LAST) ||
			(ev.win_late && s_q.cnt == ONE));
		if (!ev.track) begin
			s_d.locked = 1'b0;
		end else if (ev.edge_seen && !in_win) begin
			s_d.realign = 1'b1;
			s_d.miss = s_q.locked;
			s_d.locked = 1'b1;
			s_d.cnt = ONE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ev.realign = s_q.realign;
	assign ev.miss = s_q.miss;
endmodule : pulse_qualifier

// ---- verif/sysref_capture_monitor.sv ----
// assertion checker for the reference sync capture block.
// sees only the top module's ports; bound at the foot of this file.
`timescale 1ns/100ps

module sysref_capture_monitor #(
	parameter int DIV_PERIOD = 32,
	parameter int DW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [DW-1:0] link_div_phase,
	input wire logic link_div_reset,
	input wire logic nco_load,
	input wire logic [23:0] nco_phase,
	input wire logic sync_aligned
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_READY_NEXT:
	assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_ERR_QUAL:
	assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	AST_ALIGN_ZERO:
	assert property (link_div_reset |-> link_div_phase == '0)
		else $error("divider not zero on alignment");
	// first edge after reset is skipped: the divider restarts from 0 there
	AST_DIV_STEP:
	assert property ($past(presetn) && !link_div_reset |-> int'(link_div_phase)
		== (int'($past(link_div_phase)) + 1) % DIV_PERIOD)
		else $error("divider phase jumped");
	AST_LOAD_WITH_RESET:
	assert property (nco_load |-> link_div_reset)
		else $error("nco load apart from divider reset");
	AST_PHASE_HOLD:
	assert property ($changed(nco_phase) |-> nco_load || $past(nco_load))
		else $error("nco phase moved without load");
	AST_ALIGN_SET:
	assert property (link_div_reset |-> ##[0:1] sync_aligned)
		else $error("aligned flag not set");
	AST_ALIGN_KEEP:
	assert property (sync_aligned && !(psel && penable && pwrite)
		|=> sync_aligned)
		else $error("aligned flag lost without write");
	AST_ONE_PULSE:
	assert property (link_div_reset |=> !link_div_reset)
		else $error("divider reset longer than one cycle");

	cover property (link_div_reset);
	cover property (nco_load);
	cover property (pslverr);
endmodule : sysref_capture_monitor

bind sysref_sync_capture sysref_capture_monitor #(
	.DIV_PERIOD(DIV_PERIOD), .DW(DW)
) mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.link_div_phase(link_div_phase), .link_div_reset(link_div_reset),
	.nco_load(nco_load), .nco_phase(nco_phase), .sync_aligned(sync_aligned)
);

// ---- verif/sync_source_model.sv ----
// model of the clock distribution source: reference clock and pulses.
// the reference clock runs free, unrelated in phase to clk.
`timescale 1ns/100ps

module sync_source_model (
	input wire logic clk,
	output logic sysref_in,
	output logic ref_clk_in
);
	initial begin
		sysref_in = 1'b0;
		ref_clk_in = 1'b0;
		forever #7 ref_clk_in = ~ref_clk_in;
	end

	// idle low for gap cycles, then high for hi cycles, never under two
	task automatic pulse(input int hi, input int gap);
		repeat (gap) @(posedge clk);
		sysref_in <= 1'b1;
		repeat ((hi < 2) ? 2 : hi) @(posedge clk);
		sysref_in <= 1'b0;
	endtask : pulse
endmodule : sync_source_model

// ---- verif/tb.sv ----
// self-checking bench for the reference sync capture block.
// drives APB directly; pulses come from sync_source_model.
`timescale 1ns/100ps
`include "sysref_consts.svh"

module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic sysref_in, ref_clk_in, sysref_rx_en;
	logic link_div_reset, nco_load, sync_aligned;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] link_div_phase;
	logic [23:0] nco_phase;
	int errors, checked, n_rst, n_load;

	sysref_sync_capture #(.DIV_PERIOD(8)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sysref_in(sysref_in),
		.ref_clk_in(ref_clk_in), .sysref_rx_en(sysref_rx_en),
		.link_div_phase(link_div_phase), .link_div_reset(link_div_reset),
		.nco_load(nco_load), .nco_phase(nco_phase),
		.sync_aligned(sync_aligned)
	);
	sync_source_model src (
		.clk(pclk), .sysref_in(sysref_in), .ref_clk_in(ref_clk_in)
	);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (link_div_reset === 1'b1)
			n_rst <= n_rst + 1;
		if (nco_load === 1'b1)
			n_load <= n_load + 1;
	end

	task end_of_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			end_of_test();
		end
		@(posedge pclk);
	endtask : apb

	task automatic rdc(input string what, input logic [9:0] i,
		input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(what, rd & {24'h0, m}, {24'h0, e});
	endtask : rdc

	// the settle time covers synchroniser, retime and qualifier latency
	task automatic pw(input int gap);
		src.pulse(2, gap);
		repeat (12) @(posedge pclk);
	endtask : pw

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("clk_cfg", `IDX_CLK_CFG, 8'hff, `RST_CLK_CFG);
		chk("rx_en", sysref_rx_en, 32'h1);
		apb(1'b1, 10'h3ff, 8'h5a);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		$display("test reset done");
		apb(1'b1, `IDX_NCO_PHASE0, 8'ha1);
		apb(1'b1, `IDX_NCO_PHASE1, 8'hb2);
		apb(1'b1, `IDX_NCO_PHASE2, 8'hc3);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h26);
		pw(4);
		rdc("edges", `IDX_SYNC_STAT, 8'h0d, 8'h04);
		pw(4);
		chk("reset2", n_rst, 32'h1);
		chk("load2", n_load, 32'h1);
		chk("phase", nco_phase, 32'hc3b2a1);
		chk("aligned", sync_aligned, 32'h1);
		pw(4);
		chk("locked", n_rst, 32'h1);
		$display("test nco second pulse done");
		apb(1'b1, `IDX_SYNC_CTRL, 8'h06);
		chk("rearm", sync_aligned, 32'h0);
		pw(4);
		chk("first", n_rst, 32'h1);
		pw(4);
		chk("second", n_rst, 32'h2);
		chk("noload", n_load, 32'h1);
		$display("test second pulse done");
		apb(1'b1, `IDX_RX_CFG, 8'h04);
		chk("rx_off", sysref_rx_en, 32'h0);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h04);
		pw(4);
		chk("gated", n_rst, 32'h2);
		apb(1'b1, `IDX_RX_CFG, 8'h00);
		pw(4);
		chk("one_edge", n_rst, 32'h3);
		$display("test receiver gate done");
		apb(1'b1, `IDX_CLK_CFG, 8'h01);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h04);
		// ref clock is slower than pclk: a wide pulse spans two of its edges
		src.pulse(8, 4);
		repeat (12) @(posedge pclk);
		chk("retimed", n_rst, 32'h4);
		rdc("retime", `IDX_SYNC_STAT, 8'h21, 8'h21);
		$display("test retime done");
		apb(1'b1, `IDX_CLK_CFG, 8'h08);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h00);
		pw(4);
		chk("mode_off", n_rst, 32'h4);
		chk("off_flag", sync_aligned, 32'h0);
		$display("test mode off done");
		apb(1'b1, `IDX_SYNC_WIN, 8'h03);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h02);
		repeat (4) src.pulse(2, 6);
		src.pulse(2, 7);
		pw(9);
		chk("window", n_rst, 32'h6);
		rdc("miss", `IDX_SYNC_STAT, 8'h10, 8'h10);
		$display("test continuous done");
		end_of_test();
	end
endmodule : tb
